//--- hw/dsrw_defines.vh
// constants for the dual supply reset watchdog
// assumes a 100 MHz core clock; counts derive from times in their own units
`ifndef DSRW_DEFINES_VH
`define DSRW_DEFINES_VH

`define DSRW_CLK_HZ         100000000
// nominal reset hold, milliseconds
`define DSRW_HOLD_MS        200
// watchdog timeout, tenths of a second (1.6 s)
`define DSRW_WDOG_DS        16
`define DSRW_HOLD_CYCLES    ((`DSRW_CLK_HZ / 1000) * `DSRW_HOLD_MS)
`define DSRW_WDOG_CYCLES    ((`DSRW_CLK_HZ / 10) * `DSRW_WDOG_DS)
`define DSRW_CNT_W          28
`define DSRW_SYNC_RST       1'h1

`endif

//--- hw/dsrw_sync.v
// two flip-flop synchroniser for one asynchronous level
// assumes core_clk free running; sys_rst asynchronous active high
`timescale 1ns/1ns
module dsrw_sync #(
  parameter RST_VAL = 1'h1
) (
  input  wire core_clk,  // core clock
  input  wire sys_rst,   // async reset
  input  wire async_in,  // pin level
  output reg  sync_out   // synchronised level
);
  reg meta;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- hw/dsrw_top.v
// dual supply reset generator with edge-cleared watchdog
// assumes all inputs asynchronous to core_clk; sys_rst is power-on only
`timescale 1ns/1ns
`include "dsrw_defines.vh"
module dsrw_top #(
  parameter [`DSRW_CNT_W-1:0] HOLD_CYCLES = `DSRW_HOLD_CYCLES,
  parameter [`DSRW_CNT_W-1:0] WDOG_CYCLES = `DSRW_WDOG_CYCLES
) (
  input  wire core_clk,           // 100 MHz clock
  input  wire sys_rst,            // power-on reset, async high
  input  wire manual_reset_n,     // push-button, low asserts
  input  wire watchdog_strobe_in, // processor strobe
  input  wire strobe_float,       // high when strobe is unconnected
  input  wire supply_good_a,      // comparator a result
  input  wire supply_good_b,      // comparator b result
  output reg  reset_out_n,        // active-low reset
  output reg  reset_out           // active-high reset
);
  // ==========================================================
  // constants and helpers
  localparam [`DSRW_CNT_W-1:0] CNT_ZERO = {`DSRW_CNT_W{1'h0}};
  localparam [`DSRW_CNT_W-1:0] CNT_ONE  = {{(`DSRW_CNT_W-1){1'h0}}, 1'h1};

  // one-hot release states
  localparam [1:0]             ST_HOLD  = 2'h1;
  localparam [1:0]             ST_RUN   = 2'h2;

  // one step of either timer; limits must fit the counter width
  function [`DSRW_CNT_W-1:0] cnt_step;
    input [`DSRW_CNT_W-1:0] value;
    begin
      cnt_step = value + CNT_ONE;
    end
  endfunction

  // last count of a period of limit cycles
  function cnt_last;
    input [`DSRW_CNT_W-1:0] value;
    input [`DSRW_CNT_W-1:0] limit;
    begin
      cnt_last = (value == limit - CNT_ONE);
    end
  endfunction

  // ==========================================================
  // input synchronisers
  // reset levels read as a bad source, so reset holds after power-on
  wire mr_s;  // manual reset level
  wire wd_s;  // strobe level
  wire fl_s;  // strobe unconnected
  wire ga_s;  // supply a good
  wire gb_s;  // supply b good

  dsrw_sync #(
    .RST_VAL (1'h0)
  ) u_mr (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (manual_reset_n),
    .sync_out (mr_s)
  );

  dsrw_sync #(
    .RST_VAL (1'h0)
  ) u_wd (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (watchdog_strobe_in),
    .sync_out (wd_s)
  );

  dsrw_sync #(
    .RST_VAL (1'h1)
  ) u_fl (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (strobe_float),
    .sync_out (fl_s)
  );

  dsrw_sync #(
    .RST_VAL (1'h0)
  ) u_ga (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (supply_good_a),
    .sync_out (ga_s)
  );

  dsrw_sync #(
    .RST_VAL (1'h0)
  ) u_gb (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (supply_good_b),
    .sync_out (gb_s)
  );

  // ==========================================================
  // strobe edge detection
  reg                    wd_prev;
  wire                   wd_edge;

  // an edge in either direction counts
  assign wd_edge = wd_s ^ wd_prev;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_prev <= 1'h0;
    end else begin
      wd_prev <= wd_s;
    end
  end

  // ==========================================================
  // watchdog counter
  reg  [`DSRW_CNT_W-1:0] wd_cnt;
  reg  [`DSRW_CNT_W-1:0] next_wd_cnt;
  wire                   wd_fire;

  // firing holds the count until the reset it causes clears it
  assign wd_fire = ~fl_s & cnt_last(wd_cnt, WDOG_CYCLES);

  // cleared under reset so a slow boot is not punished
  always @* begin
    if (reset_out || fl_s || wd_edge) begin
      next_wd_cnt = CNT_ZERO;
    end else if (!wd_fire) begin
      next_wd_cnt = cnt_step(wd_cnt);
    end else begin
      next_wd_cnt = wd_cnt;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_cnt <= CNT_ZERO;
    end else begin
      wd_cnt <= next_wd_cnt;
    end
  end

  // ==========================================================
  // release sequence
  reg  [1:0]             state;
  reg  [1:0]             next_state;
  reg  [`DSRW_CNT_W-1:0] hold_cnt;
  reg  [`DSRW_CNT_W-1:0] next_hold_cnt;
  wire                   src_bad;
  wire                   restart;

  assign src_bad = ~mr_s | ~ga_s | ~gb_s;
  // any bad source or a watchdog fire restarts the full hold
  assign restart = src_bad | wd_fire;

  always @* begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    case (state)
      ST_HOLD: begin
        if (restart) begin
          next_hold_cnt = CNT_ZERO;
        end else if (cnt_last(hold_cnt, HOLD_CYCLES)) begin
          next_state = ST_RUN;
        end else begin
          next_hold_cnt = cnt_step(hold_cnt);
        end
      end
      ST_RUN: begin
        if (restart) begin
          next_state    = ST_HOLD;
          next_hold_cnt = CNT_ZERO;
        end
      end
      default: begin
        // an illegal code falls back to the safe asserted state
        next_state    = ST_HOLD;
        next_hold_cnt = CNT_ZERO;
      end
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= ST_HOLD;
      hold_cnt <= CNT_ZERO;
    end else begin
      state    <= next_state;
      hold_cnt <= next_hold_cnt;
    end
  end

  // ==========================================================
  // reset outputs
  // both taken from one next state so they can never disagree
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_out   <= 1'h1;
      reset_out_n <= 1'h0;
    end else begin
      reset_out   <= (next_state != ST_RUN);
      reset_out_n <= (next_state == ST_RUN);
    end
  end
endmodule

//--- verification/dsrw_checker.sv
// ==== checker bound onto dsrw_top; one clock, sys_rst async high
`timescale 1ns/1ns
module dsrw_checker #(parameter HOLD_CYCLES = 20, WDOG_CYCLES = 100) (
  input wire core_clk, sys_rst, manual_reset_n, watchdog_strobe_in,
  input wire strobe_float, supply_good_a, supply_good_b, reset_out_n,
  input wire reset_out);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire ok = manual_reset_n && supply_good_a && supply_good_b;
  int q = 0;
  always @(posedge core_clk)
    q <= reset_out || strobe_float || !$stable(watchdog_strobe_in) ? 0 : q + 1;
  int ok_run = 0;
  always @(posedge core_clk) ok_run <= ok ? ok_run + 1 : 0;
  AST_HLDN:
    assert property ($fell(reset_out) |-> ok_run >= HOLD_CYCLES + 2)
    else $error("reset released before a full hold of good sources");
  AST_CMP: assert property (reset_out_n != reset_out)
    else $error("bad");
  AST_MR: assert property (!manual_reset_n [*3] |=> reset_out)
    else $error("bad");
  AST_SA: assert property (!supply_good_a [*3] |=> reset_out)
    else $error("bad");
  AST_SB: assert property (!supply_good_b [*3] |=> reset_out)
    else $error("bad");
  AST_HLD:
    assert property ($fell(reset_out) |-> $past(ok, HOLD_CYCLES))
    else $error("bad");
  AST_LEN: assert property ($rose(reset_out) |=> reset_out [*8])
    else $error("bad");
  AST_WD: assert property (q <= WDOG_CYCLES + 8)
    else $error("bad");
  AST_FLT:
    assert property ($rose(reset_out) && $past(strobe_float, 4)
      |-> !$past(ok, 3)) else $error("bad");
endmodule

//--- verification/dsrw_cpu_model.sv
// ==== processor model: strobe toggles every 32 cycles while run is high and reset_out is low
`timescale 1ns/1ns
module dsrw_cpu_model (
  input  wire  core_clk,               // clock
  input  wire  reset_out,              // held in reset
  input  wire  run,                    // low: hung code
  output logic watchdog_strobe_in = 0  // strobe
);
  logic [4:0] n = 5'h0;
  always @(posedge core_clk) n <= n + 5'h1;
  always @(posedge core_clk) if (run && !reset_out && n == 5'h0)
    watchdog_strobe_in <= #1 !watchdog_strobe_in;
endmodule

//--- verification/test_dual_supply_reset_watchdog.sv
// ==== bench for dsrw_top; processor model strobes the watchdog
`timescale 1ns/1ns
module test_dual_supply_reset_watchdog;
  localparam HOLD_CYCLES = 20, WDOG_CYCLES = 100;
  logic core_clk = 0, sys_rst = 1, strobe_float = 0, run = 1;
  logic [2:0] src = 3'h7;
  wire manual_reset_n = src[2], supply_good_a = src[1], supply_good_b = src[0];
  wire watchdog_strobe_in, reset_out, reset_out_n;
  int n_errors = 0, checks = 0, ticks = 0;
  always #5 core_clk = ~core_clk;
  dsrw_top #(.HOLD_CYCLES(HOLD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .manual_reset_n(manual_reset_n),
    .watchdog_strobe_in(watchdog_strobe_in), .strobe_float(strobe_float),
    .supply_good_a(supply_good_a), .supply_good_b(supply_good_b),
    .reset_out_n(reset_out_n), .reset_out(reset_out));
  dsrw_cpu_model cpu_u (.core_clk(core_clk), .reset_out(reset_out),
    .run(run), .watchdog_strobe_in(watchdog_strobe_in));
  task cyc(input int k); repeat (k) @(posedge core_clk); #1; endtask
  task chk(input string name, input logic seen, exp); checks++;
    if (seen !== exp) begin n_errors++;
      $display("mismatch %s exp %b got %b", name, exp, seen); end
  endtask
  task chk_rst(input logic e);
    chk("reset_out", reset_out, e);
    chk("reset_out_n", reset_out_n, !e);
  endtask
  task t_rel; cyc(HOLD_CYCLES + 1); chk_rst(1);
    cyc(1); chk_rst(0);
  endtask
  task report_and_stop; $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk) if (++ticks == 2000) begin
    n_errors++; report_and_stop; end
  task t_src(input logic [2:0] v); src = v; cyc(5);
    chk_rst(1);
    src = 3'h7; t_rel;
  endtask
  task t_wdog; int i; cyc(300); chk_rst(0);
    run = 0; i = 0;
    while (i < WDOG_CYCLES + 40 && !reset_out) begin cyc(1); i++; end
    chk_rst(1);
    chk("wdog_not_early", i >= WDOG_CYCLES - 40, 1);
    run = 1; cyc(HOLD_CYCLES); chk_rst(1);
    cyc(1); chk_rst(0);
    strobe_float = 1; run = 0; cyc(300); chk_rst(0);
  endtask
  initial begin
    cyc(10); sys_rst = 0; t_rel;
    t_src(3'h3); t_src(3'h5); t_src(3'h6); t_wdog; t_src(3'h3);
    sys_rst = 1; cyc(2); chk_rst(1);
    sys_rst = 0; t_rel;
    report_and_stop;
  end
endmodule
bind dsrw_top dsrw_checker #(.HOLD_CYCLES(HOLD_CYCLES),
  .WDOG_CYCLES(WDOG_CYCLES)) chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .manual_reset_n(manual_reset_n), .watchdog_strobe_in(watchdog_strobe_in),
  .strobe_float(strobe_float), .supply_good_a(supply_good_a),
  .supply_good_b(supply_good_b), .reset_out_n(reset_out_n),
  .reset_out(reset_out));
